// ==== hdl/sdf_cfg_mem.sv ====
// Purpose: Per-slot store of filter mode and rate with a registered read port.
// Assumes: One write and one read per cycle; write and read are independent.
// Notes: Every slot resets to the power-up configuration.
`timescale 1ns/10ps
`default_nettype none
module sdf_cfg_mem #(
  parameter int SLOTS = 16,
  parameter int AW = 4,
  parameter int W = 15,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [W-1:0] wr_data,
  // Read port
  input wire logic [AW-1:0] rd_addr,
  output logic [W-1:0] rd_q
);

  logic [W-1:0] mem_q [SLOTS];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < SLOTS; i++) begin
        mem_q[i] <= RESET_VAL;
      end
    end else if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_q <= RESET_VAL;
    end else begin
      rd_q <= mem_q[rd_addr];
    end
  end

endmodule
`default_nettype wire

// ==== hdl/sdf_filter.sv ====
// Purpose: Sinc3/sinc4 decimation with averaging and fixed-rate chains, plus result timing.
// Assumes: mclk_tick pulses once per master clock cycle; mod_bit is valid with it.
// Notes: Results are raw filter sums; scaling to a final code is done downstream.
// Overview of operation
// [RL1] Power-up mode is code 0010, standalone sinc3.
// [RL2] Codes 0000/0001 sinc4 modes; rate clamped to 10.
// [RL3] Code 0011 sinc3 plus notch; full rate range.
// [RL4] Averaging modes sum eight filter outputs per result.
// [RL5] Host keeps sinc3-average rate within 0x01..0xCC.
// [RL6] Codes 0101..1000 fixed chains; rate is ignored.
// [RL7] Fixed periods 2944, 3200, 3968, 4736 ticks.
// [RL8] Standalone period is 32 ticks times rate.
// [RL9] Averaging period 352 or 320 times rate.
// [RL10] Averaging first result takes one normal period.
// [RL11] Data-ready falling edges spaced by the period.
// [RL12] Post-processing fits inside the conversion period.
// [RL13] Rate holds for one channel converting continuously.
// [RL14] All timing counted in master clock ticks.
// [RL15] Mode and rate held per slot, active applied.
// [RL16] Unused codes run as default sinc3.
`timescale 1ns/10ps
`default_nettype none
module sdf_filter
  import sdf_pkg::*;
#(
  parameter int SLOTS = 16,
  parameter int SLOT_W = 4,
  parameter int ACC_W = 52
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Modulator stream
  input wire logic mclk_tick,
  input wire logic mod_bit,
  // Configuration slot write
  input wire logic cfg_wr_en,
  input wire logic [SLOT_W-1:0] cfg_wr_slot,
  input wire logic [MODE_W-1:0] cfg_wr_mode,
  input wire logic [RATE_W-1:0] cfg_wr_rate,
  // Conversion control
  input wire logic conv_en,
  input wire logic [SLOT_W-1:0] active_slot,
  // Results
  input wire logic data_read,
  output logic [ACC_W+2:0] result_data,
  output logic result_valid,
  output logic drdy_n,
  // Status
  output logic [MODE_W-1:0] active_mode,
  output logic [PER_W-1:0] settled_conversion_period
);

  localparam int RES_W = ACC_W + 3;
  localparam int CFG_W = MODE_W + RATE_W;

  logic [CFG_W-1:0] cfg_rd;
  logic [SLOT_W-1:0] slot_q;
  logic [SLOT_W-1:0] cur_slot_q;
  logic [MODE_W-1:0] cur_mode_q;
  logic [RATE_W-1:0] cur_rate_q;
  logic [MODE_W-1:0] rd_mode;
  logic [RATE_W-1:0] rd_rate;
  logic restart;
  logic [PER_W-1:0] per_len;
  logic [PER_W-1:0] dec_len;
  logic [PER_W-1:0] per_cnt_q;
  logic [PER_W-1:0] dec_cnt_q;
  logic period_end;
  logic dec_end;
  logic [ACC_W-1:0] integ_q [4];
  logic [ACC_W-1:0] dly_q [4];
  logic [ACC_W-1:0] dly_d [4];
  logic [ACC_W-1:0] comb_out;
  logic [RES_W-1:0] avg_sum_q;
  logic [3:0] avg_cnt_q;
  logic [ACC_W-1:0] step_in;

  sdf_cfg_mem #(
    .SLOTS(SLOTS),
    .AW(SLOT_W),
    .W(CFG_W),
    .RESET_VAL({MODE_RESET, RATE_RESET})
  ) u_cfg_mem (
    .clk(core_clk),
    .rst_n(rst_n),
    .wr_en(cfg_wr_en),
    .wr_addr(cfg_wr_slot),
    .wr_data({cfg_wr_mode, cfg_wr_rate}),
    .rd_addr(active_slot),
    .rd_q(cfg_rd)
  );

  // The read port lags the slot select by one cycle, so the slot is tracked alongside.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      slot_q <= '0;
    end else begin
      slot_q <= active_slot;
    end
  end

  assign rd_mode = norm_mode(cfg_rd[CFG_W-1:RATE_W]); // RL16
  assign rd_rate = eff_rate(rd_mode, cfg_rd[RATE_W-1:0]); // RL2
  // Any change of slot or of its settings restarts the filter from clean state.
  assign restart = !conv_en || (slot_q != cur_slot_q) || (rd_mode != cur_mode_q)
                   || (rd_rate != cur_rate_q); // RL15

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_slot_q <= '0;
      cur_mode_q <= MODE_RESET; // RL1
      cur_rate_q <= RATE_RESET;
    end else if (restart) begin
      cur_slot_q <= slot_q;
      cur_mode_q <= rd_mode;
      cur_rate_q <= rd_rate;
    end
  end

  assign per_len = period_ticks(cur_mode_q, cur_rate_q); // RL8 RL9 RL7
  assign dec_len = dec_ticks(cur_mode_q, cur_rate_q); // RL6
  assign period_end = mclk_tick && (per_cnt_q == per_len - 1'b1); // RL14
  assign dec_end = mclk_tick && (dec_cnt_q == dec_len - 1'b1);
  assign step_in = mod_bit ? ACC_W'(1) : '1;

  // Both counters restart together each period so averaging lines up with the result.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      per_cnt_q <= '0;
      dec_cnt_q <= '0;
    end else if (restart || period_end) begin
      per_cnt_q <= '0; // RL10
      dec_cnt_q <= '0;
    end else if (mclk_tick) begin
      per_cnt_q <= per_cnt_q + 1'b1;
      dec_cnt_q <= dec_end ? '0 : dec_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int k = 0; k < 4; k++) begin
        integ_q[k] <= '0;
      end
    end else if (restart) begin
      for (int k = 0; k < 4; k++) begin
        integ_q[k] <= '0;
      end
    end else if (mclk_tick) begin
      integ_q[0] <= integ_q[0] + step_in;
      for (int k = 1; k < 4; k++) begin
        integ_q[k] <= integ_q[k] + integ_q[k-1];
      end
    end
  end

  // The fourth comb stage only takes part for the sinc4 chains.
  always_comb begin
    logic [ACC_W-1:0] c;
    c = is_sinc4(cur_mode_q) ? integ_q[3] : integ_q[2];
    for (int k = 0; k < 4; k++) begin
      dly_d[k] = dly_q[k];
      if ((k < 3) || is_sinc4(cur_mode_q)) begin
        dly_d[k] = c;
        c = c - dly_q[k];
      end
    end
    comb_out = c;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int k = 0; k < 4; k++) begin
        dly_q[k] <= '0;
      end
    end else if (restart) begin
      for (int k = 0; k < 4; k++) begin
        dly_q[k] <= '0;
      end
    end else if (dec_end) begin
      dly_q <= dly_d;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      avg_sum_q <= '0;
      avg_cnt_q <= '0;
    end else if (restart || period_end) begin
      avg_sum_q <= '0;
      avg_cnt_q <= '0;
    end else if (dec_end && (avg_cnt_q < AVG_LEN)) begin
      avg_sum_q <= avg_sum_q + {{3{comb_out[ACC_W-1]}}, comb_out}; // RL4
      avg_cnt_q <= avg_cnt_q + 1'b1;
    end
  end

  // The result is formed in the same cycle as the period ends, so no extra latency
  // accrues between results.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      result_data <= '0;
      result_valid <= 1'b0;
    end else begin
      result_valid <= period_end && !restart; // RL12 RL13
      if (period_end && !restart) begin
        result_data <= is_avg(cur_mode_q) ? avg_sum_q
                       : {{3{comb_out[ACC_W-1]}}, comb_out};
      end
    end
  end

  // Data-ready falls with each result and rises on a read or half a period later.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      drdy_n <= 1'b1;
    end else if (restart) begin
      drdy_n <= 1'b1;
    end else if (period_end) begin
      drdy_n <= 1'b0; // RL11
    end else if (data_read || (mclk_tick && (per_cnt_q == (per_len >> 1)))) begin
      drdy_n <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      active_mode <= MODE_RESET;
      settled_conversion_period <= '0;
    end else begin
      active_mode <= cur_mode_q;
      settled_conversion_period <= per_len;
    end
  end

  // Checking helpers: ticks since the last result and whether one was seen.
  logic [PER_W-1:0] chk_ticks_q;
  logic chk_seen_q;
  logic chk_cfg_seen_q;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      chk_ticks_q <= '0;
      chk_seen_q <= 1'b0;
      chk_cfg_seen_q <= 1'b0;
    end else begin
      if (cfg_wr_en) begin
        chk_cfg_seen_q <= 1'b1;
      end
      if (restart) begin
        chk_ticks_q <= '0;
        chk_seen_q <= 1'b0;
      end else if (period_end) begin
        chk_ticks_q <= '0;
        chk_seen_q <= 1'b1;
      end else if (mclk_tick) begin
        chk_ticks_q <= chk_ticks_q + 1'b1;
      end
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  power_up_mode_a: assert property (!chk_cfg_seen_q |-> cur_mode_q == MODE_SINC3) // RL1
    else $error("Mode left default without a configuration write");
  sinc4_rate_clamp_a: assert property (is_sinc4(cur_mode_q) |-> cur_rate_q <= SINC4_RATE_MAX) // RL2
    else $error("Sinc4 rate above clamp");
  full_rate_range_a: assert property (restart && (rd_mode == MODE_SINC3_SIXTY_HZ_EXTRA_NOTCH) // RL3
      && (cfg_rd[RATE_W-1:0] != '0) |=> cur_rate_q == $past(cfg_rd[RATE_W-1:0]))
    else $error("Sinc3 rate not taken as written");
  avg_eight_a: assert property (period_end && !restart && is_avg(cur_mode_q) // RL4
      |-> avg_cnt_q == AVG_LEN)
    else $error("Averaged result not built from eight outputs");
  fixed_period_a: assert property ((cur_mode_q == MODE_POST3) |-> per_len == POST3_TICKS) // RL7
    else $error("Fixed chain period wrong");
  std_period_a: assert property ((cur_mode_q == MODE_SINC3) // RL8
      |-> per_len == STD_MULT * PER_W'(cur_rate_q))
    else $error("Standalone period wrong");
  avg_period_a: assert property (is_avg(cur_mode_q) // RL9
      |-> per_len == (is_sinc4(cur_mode_q) ? AVG4_MULT : AVG3_MULT) * PER_W'(cur_rate_q))
    else $error("Averaging period wrong");
  drdy_spacing_a: assert property (period_end && chk_seen_q && !restart // RL11
      |-> chk_ticks_q == per_len - 1'b1)
    else $error("Data-ready spacing differs from period");
  result_with_drdy_a: assert property (result_valid |-> !drdy_n && $fell(drdy_n)) // RL12
    else $error("Result not delivered with data-ready fall");
  unused_mode_a: assert property (restart && (cfg_rd[CFG_W-1:RATE_W] > MODE_POST4) // RL16
      |=> cur_mode_q == MODE_SINC3)
    else $error("Unused code not mapped to sinc3");

  std_result_c: cover property (result_valid && (cur_mode_q == MODE_SINC3));
  avg_result_c: cover property (result_valid && is_avg(cur_mode_q));
  post_result_c: cover property (result_valid && is_post(cur_mode_q));
  slot_switch_c: cover property (conv_en && (slot_q != cur_slot_q));

endmodule
`default_nettype wire

// ==== pkg/sdf_pkg.sv ====
// Purpose: Shared constants and helpers for the decimation filter timing block.
// Assumes: Master clock ticks arrive as one-cycle pulses at 76.8 kHz.
// Notes: All periods are counted in master clock ticks.
package sdf_pkg;

  localparam int MODE_W = 4;
  localparam int RATE_W = 11;
  localparam int PER_W = 20;

  // Master clock rate and the core clock that samples its ticks.
  localparam int MCLK_HZ = 76800;
  localparam int CORE_CLK_HZ = 200000000;

  localparam logic [MODE_W-1:0] MODE_SINC4 = 4'h0;
  localparam logic [MODE_W-1:0] MODE_SINC4_AVG = 4'h1;
  localparam logic [MODE_W-1:0] MODE_SINC3 = 4'h2;
  localparam logic [MODE_W-1:0] MODE_SINC3_SIXTY_HZ_EXTRA_NOTCH = 4'h3;
  localparam logic [MODE_W-1:0] MODE_SINC3_AVG = 4'h4;
  localparam logic [MODE_W-1:0] MODE_POST1 = 4'h5;
  localparam logic [MODE_W-1:0] MODE_POST2 = 4'h6;
  localparam logic [MODE_W-1:0] MODE_POST3 = 4'h7;
  localparam logic [MODE_W-1:0] MODE_POST4 = 4'h8;

  localparam logic [MODE_W-1:0] MODE_RESET = MODE_SINC3;
  localparam logic [RATE_W-1:0] RATE_RESET = 11'h001;
  localparam logic [RATE_W-1:0] RATE_MIN = 11'h001;
  localparam logic [RATE_W-1:0] SINC4_RATE_MAX = 11'h00A;

  localparam logic [PER_W-1:0] STD_MULT = 20'h00020;
  localparam logic [PER_W-1:0] AVG4_MULT = 20'h00160;
  localparam logic [PER_W-1:0] AVG3_MULT = 20'h00140;
  localparam logic [PER_W-1:0] POST1_TICKS = 20'h00B80;
  localparam logic [PER_W-1:0] POST2_TICKS = 20'h00C80;
  localparam logic [PER_W-1:0] POST3_TICKS = 20'h00F80;
  localparam logic [PER_W-1:0] POST4_TICKS = 20'h01280;
  localparam logic [3:0] AVG_LEN = 4'h8;

  // Unused codes collapse onto the power-up filter.
  function automatic logic [MODE_W-1:0] norm_mode(input logic [MODE_W-1:0] m);
    return (m > MODE_POST4) ? MODE_RESET : m;
  endfunction

  function automatic logic is_sinc4(input logic [MODE_W-1:0] m);
    return (m == MODE_SINC4) || (m == MODE_SINC4_AVG);
  endfunction

  function automatic logic is_avg(input logic [MODE_W-1:0] m);
    return (m == MODE_SINC4_AVG) || (m == MODE_SINC3_AVG);
  endfunction

  function automatic logic is_post(input logic [MODE_W-1:0] m);
    return (m >= MODE_POST1) && (m <= MODE_POST4);
  endfunction

  // A rate of zero has no meaning and runs as the smallest rate.
  function automatic logic [RATE_W-1:0] eff_rate(input logic [MODE_W-1:0] m,
                                                  input logic [RATE_W-1:0] r);
    logic [RATE_W-1:0] v;
    v = (r < RATE_MIN) ? RATE_MIN : r;
    if (is_sinc4(m) && (v > SINC4_RATE_MAX)) begin
      v = SINC4_RATE_MAX;
    end
    return v;
  endfunction

  function automatic logic [PER_W-1:0] dec_ticks(input logic [MODE_W-1:0] m,
                                                  input logic [RATE_W-1:0] r);
    logic [PER_W-1:0] v;
    v = STD_MULT * PER_W'(r);
    if (m == MODE_POST1) begin
      v = POST1_TICKS;
    end else if (m == MODE_POST2) begin
      v = POST2_TICKS;
    end else if (m == MODE_POST3) begin
      v = POST3_TICKS;
    end else if (m == MODE_POST4) begin
      v = POST4_TICKS;
    end
    return v;
  endfunction

  function automatic logic [PER_W-1:0] period_ticks(input logic [MODE_W-1:0] m,
                                                     input logic [RATE_W-1:0] r);
    logic [PER_W-1:0] v;
    v = dec_ticks(m, r);
    if (m == MODE_SINC4_AVG) begin
      v = AVG4_MULT * PER_W'(r);
    end else if (m == MODE_SINC3_AVG) begin
      v = AVG3_MULT * PER_W'(r);
    end
    return v;
  endfunction

endpackage

// ==== verification/sdf_partner.sv ====
// Purpose: Modulator bit source and result-reading host for the decimation filter.
// Assumes: Master clock ticks every other core clock, far faster than real time.
// Notes: Drives everything at the falling edge; reads each result a few cycles after ready.
`timescale 1ns/10ps
`default_nettype none
module sdf_partner (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Host side
  input wire logic drdy_n,
  output var logic data_read,
  // Modulator side
  output var logic mclk_tick,
  output var logic mod_bit
);
  logic [7:0] phase_q;
  logic [1:0] wait_q;

  initial begin
    phase_q = 8'h00;
    wait_q = 2'h0;
    data_read = 1'b0;
    mclk_tick = 1'b0;
    mod_bit = 1'b0;
  end

  // The tick rate is compressed so whole periods fit in a short run.
  always @(negedge core_clk) begin
    phase_q <= phase_q + 8'h01;
    mclk_tick <= phase_q[0];
    mod_bit <= phase_q[3] ^ phase_q[1];
    data_read <= (wait_q == 2'h2);
    if (!rst_n || drdy_n) begin
      wait_q <= 2'h0;
    end else if (wait_q != 2'h3) begin
      wait_q <= wait_q + 2'h1;
    end
  end
endmodule
`default_nettype wire

// ==== verification/test_sdf_filter.sv ====
// Purpose: Self-checking bench for conversion timing of the decimation filter.
// Assumes: Partner supplies ticks and reads results; periods are counted in ticks.
// Notes: Result values are checked only for a settled sum of zero; timing, mode and status are also checked.
`timescale 1ns/10ps
`default_nettype none
module test_sdf_filter;
  import sdf_pkg::*;
  logic core_clk, rst_n, mclk_tick, mod_bit, cfg_wr_en, conv_en, data_read;
  logic result_valid, drdy_n;
  logic [3:0] cfg_wr_slot, active_slot;
  logic [MODE_W-1:0] cfg_wr_mode, active_mode;
  logic [RATE_W-1:0] cfg_wr_rate;
  logic [54:0] result_data;
  logic [PER_W-1:0] settled_conversion_period;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;
  int tick_cnt = 0;
  int valid_cnt = 0;
  int last_tick = 0;
  int last_gap = 0;
  logic drdy_seen = 1'b1;

  sdf_filter dut_u (.core_clk, .rst_n, .mclk_tick, .mod_bit, .cfg_wr_en, .cfg_wr_slot,
    .cfg_wr_mode, .cfg_wr_rate, .conv_en, .active_slot, .data_read, .result_data,
    .result_valid, .drdy_n, .active_mode, .settled_conversion_period);
  sdf_partner partner_u (.core_clk, .rst_n, .drdy_n, .data_read, .mclk_tick, .mod_bit);

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Sampling at the falling edge sees the values the design took at the rising edge.
  always @(negedge core_clk) begin
    cycles++;
    if (mclk_tick) begin
      tick_cnt++;
    end
    if (result_valid === 1'b1) begin
      valid_cnt++;
      last_gap = tick_cnt - last_tick;
      last_tick = tick_cnt;
      drdy_seen = drdy_n;
    end
    if (cycles == 70000) begin
      fail_count++;
      give_verdict();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic run(input logic wr, input logic [3:0] s, input logic [3:0] m,
                     input logic [10:0] r, input logic [3:0] em, input int ep,
                     input int nres);
    int t0;
    int n;
    @(negedge core_clk);
    cfg_wr_en = wr;
    cfg_wr_slot = s;
    cfg_wr_mode = m;
    cfg_wr_rate = r;
    @(negedge core_clk);
    cfg_wr_en = 1'b0;
    active_slot = s;
    conv_en = 1'b1;
    @(posedge core_clk);
    t0 = tick_cnt;
    n = valid_cnt;
    while (valid_cnt < n + 1) @(posedge core_clk);
    chk("first period", 1, (last_tick - t0 >= ep) && (last_tick - t0 <= ep + 3));
    if (nres == 2) begin
      while (valid_cnt < n + 2) @(posedge core_clk);
      chk("settled period", ep, last_gap);
      chk("ready low", 0, drdy_seen);
    end
    chk("period port", ep, settled_conversion_period);
    chk("applied mode", em, active_mode);
    $display("test slot %0d mode %0d done", s, m);
  endtask

  initial begin
    int n;
    rst_n = 1'b0;
    cfg_wr_en = 1'b0;
    cfg_wr_slot = 4'h0;
    cfg_wr_mode = 4'h0;
    cfg_wr_rate = 11'h000;
    conv_en = 1'b0;
    active_slot = 4'h0;
    repeat (12) @(negedge core_clk);
    chk("reset mode", 4'h2, active_mode);
    chk("reset ready", 1, drdy_n);
    chk("reset valid", 0, result_valid);
    rst_n = 1'b1;
    run(1'b0, 4'h0, 4'h0, 11'h000, MODE_SINC3, 32 * 1, 2);
    run(1'b1, 4'h1, MODE_SINC4, 11'h00B, MODE_SINC4, 32 * 10, 2);
    run(1'b1, 4'h2, MODE_SINC4_AVG, 11'h002, MODE_SINC4_AVG, 352 * 2, 2);
    run(1'b1, 4'h3, MODE_SINC3, 11'h003, MODE_SINC3, 32 * 3, 2);
    run(1'b1, 4'h4, MODE_SINC3_SIXTY_HZ_EXTRA_NOTCH, 11'h005, MODE_SINC3_SIXTY_HZ_EXTRA_NOTCH, 32 * 5, 2);
    run(1'b1, 4'h5, MODE_SINC3_AVG, 11'h001, MODE_SINC3_AVG, 320 * 1, 2);
    run(1'b1, 4'h6, MODE_POST1, 11'h7FF, MODE_POST1, 2944, 2);
    run(1'b1, 4'h7, MODE_POST2, 11'h001, MODE_POST2, 3200, 1);
    run(1'b1, 4'h8, MODE_POST3, 11'h0CC, MODE_POST3, 3968, 1);
    run(1'b1, 4'h9, MODE_POST4, 11'h000, MODE_POST4, 4736, 2);
    run(1'b1, 4'hA, 4'hF, 11'h002, MODE_SINC3, 32 * 2, 2);
    run(1'b1, 4'hB, 4'h9, 11'h001, MODE_SINC3, 32 * 1, 2);
    run(1'b0, 4'h3, 4'h0, 11'h000, MODE_SINC3, 32 * 3, 2);
    // The partner's bit pattern sums to zero over every eight ticks, so a settled sum is zero.
    n = valid_cnt;
    while (valid_cnt < n + 2) @(posedge core_clk);
    chk("settled result", 0, 32'(result_data != 55'h0));
    $display("test settled result done");
    @(negedge core_clk);
    conv_en = 1'b0;
    repeat (4) @(posedge core_clk);
    n = valid_cnt;
    repeat (200) @(posedge core_clk);
    chk("results while stopped", n, valid_cnt);
    chk("ready while stopped", 1, drdy_n);
    $display("test stopped conversion done");
    give_verdict();
  end
endmodule
`default_nettype wire
